// ===== core/ascc_pkg.sv
// Purpose: Shared constants for the converter sample and convert control block
// Assumes: 32-bit register port, 40 MHz clock
// Notes:   Offsets are word-aligned byte addresses
package ascc_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] ADDR_CONTROL_ONE        = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_ONE_CLEAR  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_ONE_SET    = 8'h08;
  localparam logic [7:0] ADDR_CONTROL_ONE_INVERT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS         = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK           = 8'h14;

  // ********************************************************
  // Control register field positions
  // ********************************************************
  localparam int POS_DONE      = 0;
  localparam int POS_SAMPLE    = 1;
  localparam int POS_AUTO      = 2;
  localparam int POS_STOP      = 4;
  localparam int POS_TRIG_LO   = 5;
  localparam int TRIG_WIDTH    = 3;

  // Writable bits of the control register; conversion status is hardware owned
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_00F6;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [2:0] RESET_TRIG   = 3'h0;
  localparam logic       RESET_STOP   = 1'b0;
  localparam logic       RESET_AUTO   = 1'b0;
  localparam logic       RESET_SAMPLE = 1'b0;
  localparam logic       RESET_DONE   = 1'b0;
  localparam logic [1:0] RESET_IRQ    = 2'h0;

  // ********************************************************
  // Interrupt status bits
  // ********************************************************
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_STOP_BIT  = 1;
  localparam int IRQ_WIDTH     = 2;

  // ********************************************************
  // Trigger source encodings
  // ********************************************************
  localparam logic [2:0] TRIG_MANUAL   = 3'h0;
  localparam logic [2:0] TRIG_EXT_PIN  = 3'h1;
  localparam logic [2:0] TRIG_TIMER    = 3'h2;
  localparam logic [2:0] TRIG_COUNTER  = 3'h7;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_PS      = 25000;
  localparam int SAMPLE_TIME_NS     = 500;
  localparam int SAMPLE_CYCLES      = (SAMPLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONVERT_TIME_NS    = 300;
  localparam int CONVERT_CYCLES     = (CONVERT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    ASCC_IDLE,
    ASCC_SAMPLE,
    ASCC_CONVERT
  } ascc_state_type;

endpackage

// ===== core/ascc_edge_sync.sv
// Purpose: Two-stage synchroniser with rising-edge pulse output
// Assumes: Input is asynchronous to CLK
// Notes:   Pulse lasts one cycle per rising edge
`timescale 1ns/10ps
module ascc_edge_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);

  logic stage_one;
  logic stage_two;
  logic stage_old;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_old <= 1'b0;
    end else begin
      stage_one <= async_in;
      stage_two <= stage_one;
      stage_old <= stage_two;
    end
  end

  assign level = stage_two;
  assign rise  = stage_two & ~stage_old;

endmodule

// ===== core/ascc_top.sv
// Purpose: Sample and convert sequencing for a successive-approximation converter
// Assumes: Conversion end comes from the internal convert counter; trigger inputs are asynchronous pins
// Notes:   Register port has read data one cycle after the read strobe
//
// How it works
// - Trigger code 111 ends sampling from the internal sample counter.
// - Trigger code 010 uses timer three period match to start conversion.
// - Trigger code 001 uses rising edge on external pin zero.
// - Trigger code 000: software clearing sample enable starts conversion.
// - Stop bit set: first interrupt halts sequence and clears auto start.
// - Stop bit clear: conversions keep running and overwrite results.
// - Auto start set: sampling restarts after conversion, sample enable set.
// - Auto start clear: sampling begins only on software writing sample enable.
// - Sample enable reads one while sampling, zero while holding.
// - Done flag reads one after a finished conversion, else zero.
// - Software clear of done leaves sampling and conversion untouched.
// - In automatic mode hardware clears done one cycle after next sample begins.
// - Clear alias clears written-one bits, done included, leaves others and bit 3.
// - Set alias sets written-one bits, leaves others and read-only bits.
// - Invert alias toggles written-one bits, leaves others and read-only bits.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module ascc_top
  import ascc_pkg::*;
#(
  parameter int SAMPLE_COUNT  = SAMPLE_CYCLES,
  parameter int CONVERT_COUNT = CONVERT_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        TIMER_MATCH,
  input  wire logic        EXT_IRQ_ZERO_PIN,
  output logic             CONVERT_START,
  output logic             SAMPLING,
  output logic             IRQ
);

  // ********************************************************
  // Parameter checks
  // ********************************************************
  // Counts must fit the 8-bit sequencer counter
  if (SAMPLE_COUNT < 1 || SAMPLE_COUNT > 255 || CONVERT_COUNT < 1 || CONVERT_COUNT > 255) begin : g_count_check
    $error("ascc_top: counts must lie in 1..255");
  end

  // ********************************************************
  // Reset release
  // ********************************************************
  logic reset_meta;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reset_meta <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      reset_meta <= 1'b1;
      rst_n      <= reset_meta;
    end
  end

  // ********************************************************
  // Trigger inputs
  // ********************************************************
  logic timer_rise;
  logic pin_rise;

  ascc_edge_sync timer_sync (
    .clk      (CLK),
    .reset_n  (rst_n),
    .async_in (TIMER_MATCH),
    .level    (),
    .rise     (timer_rise)
  );

  ascc_edge_sync pin_sync (
    .clk      (CLK),
    .reset_n  (rst_n),
    .async_in (EXT_IRQ_ZERO_PIN),
    .level    (),
    .rise     (pin_rise)
  );

  // ********************************************************
  // Register decode
  // ********************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // Alias write resolves to the new control image
  function automatic logic [31:0] alias_apply(input logic [7:0] addr, input logic [31:0] cur,
                                              input logic [31:0] data);
    logic [31:0] sel;
    sel = data & CONTROL_WRITE_MASK;
    if (hit(addr, ADDR_CONTROL_ONE_CLEAR)) begin
      alias_apply = cur & ~sel;
    end else if (hit(addr, ADDR_CONTROL_ONE_SET)) begin
      alias_apply = cur | sel;
    end else if (hit(addr, ADDR_CONTROL_ONE_INVERT)) begin
      alias_apply = cur ^ sel;
    end else begin
      alias_apply = (cur & ~CONTROL_WRITE_MASK) | sel;
    end
  endfunction

  logic [2:0]  trigger_source_select;
  logic        stop_on_first_irq;
  logic        auto_sample_start;
  logic        sample_enable;
  logic        done;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;

  logic [31:0] control_image;
  logic        ctrl_write;
  logic [31:0] next_control;

  always_comb begin
    control_image = 32'h0000_0000;
    control_image[POS_DONE]   = done;
    control_image[POS_SAMPLE] = sample_enable;
    control_image[POS_AUTO]   = auto_sample_start;
    control_image[POS_STOP]   = stop_on_first_irq;
    control_image[POS_TRIG_LO +: TRIG_WIDTH] = trigger_source_select;
  end

  assign ctrl_write = WR & (hit(ADDR, ADDR_CONTROL_ONE) | hit(ADDR, ADDR_CONTROL_ONE_CLEAR) |
                            hit(ADDR, ADDR_CONTROL_ONE_SET) | hit(ADDR, ADDR_CONTROL_ONE_INVERT));
  assign next_control = alias_apply(ADDR, control_image, WDATA);

  // Done clear is its own path since done is not in the write mask
  logic done_sw_clear;
  assign done_sw_clear = WR & hit(ADDR, ADDR_CONTROL_ONE_CLEAR) & WDATA[POS_DONE];

  // ********************************************************
  // Sequencer
  // ********************************************************
  ascc_state_type state;
  logic [7:0]     count;
  logic           sample_end;
  logic           convert_end;
  logic           sw_sample_clear;
  logic           sw_sample_set;

  assign sw_sample_set   = ctrl_write & next_control[POS_SAMPLE] & ~sample_enable;
  assign sw_sample_clear = ctrl_write & ~next_control[POS_SAMPLE] & sample_enable;
  assign convert_end     = (state == ASCC_CONVERT) && (count == 8'(CONVERT_COUNT - 1));

  always_comb begin
    sample_end = 1'b0;
    unique case (trigger_source_select)
      TRIG_COUNTER: sample_end = (count == 8'(SAMPLE_COUNT - 1));
      TRIG_TIMER:   sample_end = timer_rise;
      TRIG_EXT_PIN: sample_end = pin_rise;
      TRIG_MANUAL:  sample_end = sw_sample_clear;
      default:      sample_end = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASCC_IDLE;
      count <= 8'h00;
    end else begin
      unique case (state)
        ASCC_IDLE: begin
          count <= 8'h00;
          if (sw_sample_set) begin
            state <= ASCC_SAMPLE;
          end
        end
        ASCC_SAMPLE: begin
          count <= count + 8'h01;
          if (sample_end) begin
            state <= ASCC_CONVERT;
            count <= 8'h00;
          end else if (ctrl_write && !next_control[POS_SAMPLE]) begin
            state <= ASCC_IDLE;
          end
        end
        ASCC_CONVERT: begin
          count <= count + 8'h01;
          if (convert_end) begin
            count <= 8'h00;
            if (auto_sample_start && !stop_on_first_irq) begin
              state <= ASCC_SAMPLE;
            end else begin
              state <= ASCC_IDLE;
            end
          end
        end
      endcase
    end
  end

  logic restart;
  logic restart_pending;
  assign restart = convert_end & auto_sample_start & ~stop_on_first_irq;

  // ********************************************************
  // Control bits
  // ********************************************************
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      trigger_source_select <= RESET_TRIG;
      stop_on_first_irq     <= RESET_STOP;
      auto_sample_start     <= RESET_AUTO;
    end else begin
      if (ctrl_write) begin
        trigger_source_select <= next_control[POS_TRIG_LO +: TRIG_WIDTH];
        stop_on_first_irq     <= next_control[POS_STOP];
        auto_sample_start     <= next_control[POS_AUTO];
      end
      if (convert_end && stop_on_first_irq) begin
        auto_sample_start <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sample_enable <= RESET_SAMPLE;
    end else if (restart) begin
      sample_enable <= 1'b1;
    end else if (state == ASCC_SAMPLE && sample_end) begin
      sample_enable <= 1'b0;
    end else if (ctrl_write && state != ASCC_CONVERT) begin
      sample_enable <= next_control[POS_SAMPLE];
    end
  end

  // done flag, set wins over clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done <= RESET_DONE;
    end else if (convert_end) begin
      done <= 1'b1;
    end else if (done_sw_clear || restart_pending) begin
      done <= 1'b0;
    end
  end

  // Automatic restart clears done one cycle after it was set, one cycle after sampling begins
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      restart_pending <= 1'b0;
    end else begin
      restart_pending <= restart;
    end
  end

  // ********************************************************
  // Interrupts
  // ********************************************************
  logic [1:0] irq_event;
  logic       status_read;

  assign irq_event[IRQ_DONE_BIT] = convert_end;
  assign irq_event[IRQ_STOP_BIT] = convert_end & stop_on_first_irq;
  assign status_read = RD & hit(ADDR, ADDR_IRQ_STATUS);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RESET_IRQ;
    end else begin
      irq_status <= (status_read ? 2'h0 : irq_status) | irq_event;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= RESET_IRQ;
    end else if (WR && hit(ADDR, ADDR_IRQ_MASK)) begin
      irq_mask <= WDATA[IRQ_WIDTH-1:0];
    end
  end

  // ********************************************************
  // Outputs and read data
  // ********************************************************
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ           <= 1'b0;
      CONVERT_START <= 1'b0;
      SAMPLING      <= 1'b0;
    end else begin
      IRQ           <= |(irq_status & irq_mask);
      CONVERT_START <= (state == ASCC_SAMPLE) && sample_end;
      SAMPLING      <= sample_enable;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h0000_0000;
    end else if (RD && hit(ADDR, ADDR_CONTROL_ONE)) begin
      RDATA <= control_image;
    end else if (RD && hit(ADDR, ADDR_IRQ_STATUS)) begin
      RDATA <= {30'h0, irq_status};
    end else if (RD && hit(ADDR, ADDR_IRQ_MASK)) begin
      RDATA <= {30'h0, irq_mask};
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  done_on_finish_a: assert property (@(posedge CLK) disable iff (!rst_n)
    convert_end |=> done)
    else $error("done not set after conversion end");

  stop_clears_auto_a: assert property (@(posedge CLK) disable iff (!rst_n)
    convert_end && stop_on_first_irq |=> !auto_sample_start && state == ASCC_IDLE)
    else $error("stop bit did not halt sequence");

  auto_restart_a: assert property (@(posedge CLK) disable iff (!rst_n)
    restart |=> sample_enable && state == ASCC_SAMPLE)
    else $error("auto restart failed");

  done_auto_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    restart |=> ##1 !done)
    else $error("done persisted into next sample");

  sample_reads_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ASCC_CONVERT |-> !sample_enable)
    else $error("sample enable high while holding");

  timer_trigger_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ASCC_SAMPLE && trigger_source_select == TRIG_TIMER && timer_rise |=> state == ASCC_CONVERT)
    else $error("timer match did not start conversion");

  pin_trigger_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ASCC_SAMPLE && trigger_source_select == TRIG_EXT_PIN && pin_rise |=> state == ASCC_CONVERT)
    else $error("pin edge did not start conversion");

  clear_alias_a: assert property (@(posedge CLK) disable iff (!rst_n)
    WR && hit(ADDR, ADDR_CONTROL_ONE_CLEAR) && WDATA[POS_STOP] |=> !stop_on_first_irq)
    else $error("clear alias failed");

  set_alias_a: assert property (@(posedge CLK) disable iff (!rst_n)
    WR && hit(ADDR, ADDR_CONTROL_ONE_SET) && WDATA[POS_STOP] |=> stop_on_first_irq)
    else $error("set alias failed");

  irq_raise_a: assert property (@(posedge CLK) disable iff (!rst_n)
    convert_end && irq_mask[IRQ_DONE_BIT] |-> ##2 IRQ)
    else $error("completion interrupt missing");

endmodule

// ===== dv/tb_adc_sample_convert_control.sv
// Purpose: Self-checking bench for the sample and convert control block
// Assumes: Short sample and convert counts keep the run brief
// Notes:   Read results are compared by a monitor against a queue of notes
`timescale 1ns/10ps
module tb_adc_sample_convert_control;
  import ascc_pkg::*;

  localparam int SCNT = 8;
  localparam int CCNT = 6;

  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    string       name;
  } ascc_note_type;

  logic          clk;
  logic          reset_n;
  logic [7:0]    addr;
  logic [31:0]   wdata;
  logic          wr_s;
  logic          rd;
  logic [31:0]   rdata;
  logic          tmr;
  logic          pin;
  logic          conv_start;
  logic          sampling;
  logic          irq;
  logic          rd_pend;
  logic [31:0]   seed;
  logic [2:0]    code;
  int            cs_count;
  int            c0;
  int            err_total;
  int            n_tests;
  ascc_note_type notes[$];
  ascc_note_type note;
  logic [2:0]    codes[3] = '{TRIG_EXT_PIN, TRIG_TIMER, TRIG_COUNTER};

  ascc_top #(.SAMPLE_COUNT(SCNT), .CONVERT_COUNT(CCNT)) DUT (
    .CLK              (clk),
    .RESET_N          (reset_n),
    .ADDR             (addr),
    .WDATA            (wdata),
    .WR               (wr_s),
    .RD               (rd),
    .RDATA            (rdata),
    .TIMER_MATCH      (tmr),
    .EXT_IRQ_ZERO_PIN (pin),
    .CONVERT_START    (conv_start),
    .SAMPLING         (sampling),
    .IRQ              (irq)
  );

  always #12.5 clk = ~clk;

  // ********************************************************
  // Checking
  // ********************************************************
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so compare there
  always @(posedge clk) begin
    if (rd_pend === 1'b1) begin
      note = notes.pop_front();
      check(note.name, rdata & note.msk, note.exp);
    end
    rd_pend <= rd;
  end

  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      cs_count <= cs_count + 1;
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ********************************************************
  // Bus and pin drivers
  // ********************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    notes.push_back('{e, m, n});
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random width, since the synchroniser must see any pulse of a cycle or more
  task automatic pulse(input bit use_timer);
    seed = lfsr(seed);
    @(posedge clk);
    if (use_timer) tmr <= 1'b1;
    else pin <= 1'b1;
    repeat (1 + seed[1:0]) @(posedge clk);
    tmr <= 1'b0;
    pin <= 1'b0;
  endtask

  task automatic wait_start(input int limit);
    int i;
    int c;
    c = cs_count;
    i = 0;
    while (cs_count == c && i < limit) begin
      @(posedge clk);
      i++;
    end
    check("convert start", 32'(cs_count > c), 32'h1);
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_s = 1'b0;
    rd = 1'b0;
    tmr = 1'b0;
    pin = 1'b0;
    rd_pend = 1'b0;
    cs_count = 0;
    seed = 32'h5991;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    idle(4);
    rd_chk(ADDR_CONTROL_ONE, 32'h0, 32'hFFFF_FFFF, "control reset");
    rd_chk(ADDR_IRQ_STATUS, 32'h0, 32'hFFFF_FFFF, "status reset");
    rd_chk(ADDR_IRQ_MASK, 32'h0, 32'hFFFF_FFFF, "mask reset");
    $display("test reset done");

    wr(ADDR_CONTROL_ONE, 32'h0000_0002);
    idle(SCNT + 6);
    check("manual sampling", 32'(sampling), 32'h1);
    rd_chk(ADDR_CONTROL_ONE, 32'h2, 32'h3, "sample enable");
    wr(ADDR_CONTROL_ONE, 32'h0000_0000);
    wait_start(10);
    idle(CCNT + 4);
    rd_chk(ADDR_CONTROL_ONE, 32'h1, 32'h3, "done manual");
    check("masked irq", 32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    idle(3);
    check("irq raised", 32'(irq), 32'h1);
    rd_chk(ADDR_IRQ_STATUS, 32'h1, 32'h3, "done event");
    idle(3);
    check("irq cleared", 32'(irq), 32'h0);
    $display("test manual done");

    wr(ADDR_CONTROL_ONE_SET, 32'h0000_0011);
    rd_chk(ADDR_CONTROL_ONE, 32'h11, 32'hFF, "set alias");
    rd_chk(ADDR_CONTROL_ONE_SET, 32'h0, 32'hFFFF_FFFF, "alias read");
    wr(ADDR_CONTROL_ONE_INVERT, 32'h0000_0091);
    rd_chk(ADDR_CONTROL_ONE, 32'h81, 32'hFF, "invert alias");
    wr(ADDR_CONTROL_ONE_CLEAR, 32'h0000_0081);
    rd_chk(ADDR_CONTROL_ONE, 32'h0, 32'hFF, "clear alias");
    seed = lfsr(seed);
    wr(8'h3C, seed);
    rd_chk(8'h3C, 32'h0, 32'hFFFF_FFFF, "unmapped read");
    rd_chk(ADDR_CONTROL_ONE, 32'h0, 32'hFFFF_FFFF, "after unmapped");
    $display("test aliases done");

    foreach (codes[k]) begin
      wr(ADDR_CONTROL_ONE, 32'({codes[k], 5'b00010}));
      // Clearing done mid-sample must not disturb the sequence
      wr(ADDR_CONTROL_ONE_CLEAR, 32'h0000_0001);
      if (codes[k] != TRIG_COUNTER) begin
        pulse(codes[k] == TRIG_EXT_PIN);
        idle(6);
        check("other source", 32'(sampling), 32'h1);
        pulse(codes[k] == TRIG_TIMER);
      end
      wait_start(SCNT + 10);
      idle(CCNT + 4);
      rd_chk(ADDR_CONTROL_ONE, 32'h1, 32'h3, "done trigger");
    end
    rd_chk(ADDR_IRQ_STATUS, 32'h1, 32'h1, "status trigger");
    seed = lfsr(seed);
    code = 3'h3 + {1'b0, seed[1:0]};
    c0 = cs_count;
    wr(ADDR_CONTROL_ONE, 32'({code, 5'b00010}));
    pulse(1'b1);
    pulse(1'b0);
    idle(SCNT + 8);
    check("reserved code", 32'(sampling), 32'h1);
    wr(ADDR_CONTROL_ONE_CLEAR, 32'h0000_0002);
    idle(3);
    check("reserved abort", 32'(sampling), 32'h0);
    check("reserved starts", 32'(cs_count), 32'(c0));
    $display("test triggers done");

    wr(ADDR_CONTROL_ONE, 32'h0000_00E6);
    wait_start(SCNT + CCNT + 20);
    wait_start(SCNT + CCNT + 20);
    rd_chk(ADDR_CONTROL_ONE, 32'h4, 32'h5, "auto done clear");
    wr(ADDR_CONTROL_ONE_SET, 32'h0000_0010);
    idle(SCNT + CCNT + 26);
    rd_chk(ADDR_CONTROL_ONE, 32'h1, 32'h7, "stopped image");
    rd_chk(ADDR_IRQ_STATUS, 32'h3, 32'h3, "stop event");
    c0 = cs_count;
    idle(SCNT + CCNT + 10);
    check("no restart", 32'(cs_count), 32'(c0));
    check("stopped sampling", 32'(sampling), 32'h0);
    wr(ADDR_CONTROL_ONE_CLEAR, 32'h0000_0010);
    rd_chk(ADDR_CONTROL_ONE, 32'hE1, 32'hFF, "stop cleared");
    $display("test auto done");
    idle(4);
    give_verdict();
  end

  // Whole run is about three hundred cycles; this limit of 5000 cycles is over fifteen times that
  initial begin
    #(25 * 5000);
    err_total++;
    give_verdict();
  end

endmodule
